// >>> obtr_pkg.sv
/*
  Constants shared by the octal bus transceiver and register block.
  Assumes a single 25 MHz clock; every pin is synchronous to it.
*/
// Function
// - Enabled, direction low, live B drives A
// - Enabled, direction low, stored B drives A
// - Enabled, direction high, live A drives B
// - Enabled, direction high, stored A drives B
// - Capture on every capture-clock rise, always
// - Only enable and direction decide driving
// - Disabled: both ports released, capture continues
// - A captures on A clock, B on B
// - True or inverting variant, all paths
package obtr_pkg;

  // Data width of each bus
  localparam int DATA_W = 8;

  // APB geometry
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // Register byte offsets
  localparam logic [APB_AW-1:0] CTRL_OFS = 8'h00;
  localparam logic [APB_AW-1:0] STATUS_OFS = 8'h04;
  localparam logic [APB_AW-1:0] CAPCNT_OFS = 8'h08;

  // CTRL fields
  localparam int CTRL_CLR_BIT = 0;

  // STATUS fields
  localparam int STAT_AREG_LSB = 0;
  localparam int STAT_BREG_LSB = 8;
  localparam int STAT_OEN_BIT = 16;
  localparam int STAT_DIR_BIT = 17;
  localparam int STAT_SAB_BIT = 18;
  localparam int STAT_SBA_BIT = 19;

  // CAPCNT fields
  localparam int CNT_W = 16;
  localparam int CNT_A_LSB = 0;
  localparam int CNT_B_LSB = 16;

  // Reset values
  localparam logic [DATA_W-1:0] BUS_OUT_RST = 8'h00;
  localparam logic [APB_DW-1:0] PRDATA_RST = 32'h00000000;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

  // APB slave states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ANSWER = 3'b010,
    ST_DONE = 3'b100
  } obtr_apb_state_t;

endpackage : obtr_pkg

// >>> obtr_capture_reg.sv
/*
  One eight-bit capture register with its own capture clock input.
  Assumes the capture clock pin is synchronous to clk and slower than it.
*/
`timescale 1ns/100ps
module obtr_capture_reg
  import obtr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Capture side
  input wire logic capClk,
  input wire logic [DATA_W-1:0] busIn,
  // Results
  output logic [DATA_W-1:0] stored,
  output logic capPulse
);

  logic capClkPrev_reg;
  logic [DATA_W-1:0] stored_reg;

  // Rising edge of the capture clock
  assign capPulse = capClk & ~capClkPrev_reg;
  assign stored = stored_reg;

  // Previous capture clock level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      capClkPrev_reg <= 1'b0;
    end else begin
      capClkPrev_reg <= capClk;
    end
  end

  // Data holds until next edge, deliberately no reset
  always_ff @(posedge clk) begin
    if (capPulse) begin
      stored_reg <= busIn;
    end
  end

endmodule : obtr_capture_reg

// >>> obtr_transceiver.sv
/*
  Octal bus transceiver with a capture register per bus and an APB
  status window. Assumes all pins synchronous to clk and bus agents that
  never drive the port this block is currently driving.
*/
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/100ps
module obtr_transceiver
  import obtr_pkg::*;
#(
  parameter bit INVERT_DATA = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transfer controls
  input wire logic outputEnableN,
  input wire logic dirSelect,
  input wire logic aToBSourceSelect,
  input wire logic bToASourceSelect,
  input wire logic aSideCaptureClock,
  input wire logic bSideCaptureClock,
  // Bus A pins
  input wire logic [DATA_W-1:0] aIn,
  output logic [DATA_W-1:0] aOut,
  output logic aOeN,
  // Bus B pins
  input wire logic [DATA_W-1:0] bIn,
  output logic [DATA_W-1:0] bOut,
  output logic bOeN
);

  logic [DATA_W-1:0] aStored;
  logic [DATA_W-1:0] bStored;
  logic aCapPulse;
  logic bCapPulse;
  logic [DATA_W-1:0] invMask;
  logic [DATA_W-1:0] aSource;
  logic [DATA_W-1:0] bSource;
  logic [DATA_W-1:0] aNext;
  logic [DATA_W-1:0] bNext;
  logic aDrive;
  logic bDrive;
  logic [DATA_W-1:0] aOut_reg;
  logic [DATA_W-1:0] bOut_reg;
  logic aOeN_reg;
  logic bOeN_reg;
  logic [CNT_W-1:0] aCnt_reg;
  logic [CNT_W-1:0] bCnt_reg;
  logic [CNT_W-1:0] aCnt_next;
  logic [CNT_W-1:0] bCnt_next;
  obtr_apb_state_t state_reg;
  obtr_apb_state_t state_next;
  logic [APB_DW-1:0] prdata_reg;
  logic [APB_DW-1:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;
  logic apbAccess;
  logic apbCommit;
  logic hitCtrl;
  logic hitStatus;
  logic hitCapcnt;
  logic hitAny;
  logic clearCounts;
  logic [APB_DW-1:0] statusWord;
  logic [APB_DW-1:0] capcntWord;
  logic [APB_DW-1:0] readMux;

  // A-side register, clocked by the A capture clock
  obtr_capture_reg aCapture (
    .clk(clk),
    .reset(reset),
    .capClk(aSideCaptureClock),
    .busIn(aIn),
    .stored(aStored),
    .capPulse(aCapPulse)
  );

  // B-side register, clocked by the B capture clock
  obtr_capture_reg bCapture (
    .clk(clk),
    .reset(reset),
    .capClk(bSideCaptureClock),
    .busIn(bIn),
    .stored(bStored),
    .capPulse(bCapPulse)
  );

  // Who drives: only enable and direction count
  assign aDrive = ~outputEnableN & ~dirSelect;
  assign bDrive = ~outputEnableN & dirSelect;

  // Source selects pick live or stored data only
  assign bSource = bToASourceSelect ? bStored : bIn;
  assign aSource = aToBSourceSelect ? aStored : aIn;

  // Build-time inversion applies to both paths
  assign invMask = INVERT_DATA ? {DATA_W{1'b1}} : {DATA_W{1'b0}};
  assign aNext = bSource ^ invMask;
  assign bNext = aSource ^ invMask;

  // Pin drivers, one clock behind their inputs
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aOut_reg <= BUS_OUT_RST;
      bOut_reg <= BUS_OUT_RST;
      aOeN_reg <= 1'b1;
      bOeN_reg <= 1'b1;
    end else begin
      aOut_reg <= aNext;
      bOut_reg <= bNext;
      aOeN_reg <= ~aDrive;
      bOeN_reg <= ~bDrive;
    end
  end

  assign aOut = aOut_reg;
  assign bOut = bOut_reg;
  assign aOeN = aOeN_reg;
  assign bOeN = bOeN_reg;

  // APB decode
  assign apbAccess = psel & penable;
  assign apbCommit = apbAccess & (state_reg == ST_ANSWER);
  assign hitCtrl = (paddr == CTRL_OFS);
  assign hitStatus = (paddr == STATUS_OFS);
  assign hitCapcnt = (paddr == CAPCNT_OFS);
  assign hitAny = hitCtrl | hitStatus | hitCapcnt;
  assign clearCounts = apbCommit & pwrite & hitCtrl & pwdata[CTRL_CLR_BIT];

  // Read words
  assign statusWord = {12'h000, bToASourceSelect, aToBSourceSelect, dirSelect, outputEnableN, bStored, aStored};
  assign capcntWord = {bCnt_reg, aCnt_reg};
  assign readMux = hitStatus ? statusWord : (hitCapcnt ? capcntWord : PRDATA_RST);

  // Capture counters; a capture in the clear cycle still counts
  assign aCnt_next = clearCounts ? (aCapPulse ? 16'h0001 : CNT_RST)
                                 : (aCapPulse ? aCnt_reg + 16'h0001 : aCnt_reg);
  assign bCnt_next = clearCounts ? (bCapPulse ? 16'h0001 : CNT_RST)
                                 : (bCapPulse ? bCnt_reg + 16'h0001 : bCnt_reg);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aCnt_reg <= CNT_RST;
      bCnt_reg <= CNT_RST;
    end else begin
      aCnt_reg <= aCnt_next;
      bCnt_reg <= bCnt_next;
    end
  end

  // APB state sequencing: one wait cycle, then answer
  always_comb begin
    state_next = state_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    case (state_reg)
      ST_IDLE: begin
        if (apbAccess) begin
          state_next = ST_ANSWER;
          prdata_next = pwrite ? PRDATA_RST : readMux;
          pslverr_next = ~hitAny;
        end
      end
      ST_ANSWER: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
        prdata_next = PRDATA_RST;
        pslverr_next = 1'b0;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // APB outputs from flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      prdata_reg <= PRDATA_RST;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= (state_next == ST_ANSWER);
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

endmodule : obtr_transceiver

// >>> obtr_properties.sv
/*
  Pin checker for the transceiver: drive side, data source, isolation.
  Assumes a bind onto obtr_transceiver.
*/
`timescale 1ns/100ps
module obtr_properties
  import obtr_pkg::*;
#(
  parameter bit INVERT_DATA = 1'b0
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Controls
  input wire logic outputEnableN,
  input wire logic dirSelect,
  input wire logic aToBSourceSelect,
  input wire logic bToASourceSelect,
  input wire logic aSideCaptureClock,
  input wire logic bSideCaptureClock,
  // Bus pins
  input wire logic [DATA_W-1:0] aIn,
  input wire logic [DATA_W-1:0] bIn,
  input wire logic [DATA_W-1:0] aOut,
  input wire logic [DATA_W-1:0] bOut,
  input wire logic aOeN,
  input wire logic bOeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [1:0] age_reg;
  logic aPrev_reg, bPrev_reg;
  logic [DATA_W-1:0] aSt_reg, bSt_reg;
  // Path selection decode
  wire logic [DATA_W-1:0] mask = {DATA_W{INVERT_DATA}};
  wire logic up = age_reg[1];
  wire logic toA = !outputEnableN && !dirSelect;
  wire logic toB = !outputEnableN && dirSelect;
  wire logic stA = toA && bToASourceSelect;
  wire logic stB = toB && aToBSourceSelect;
  // Settle count after reset, so registered pins are valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      age_reg <= 2'h0;
    end else if (!up) begin
      age_reg <= age_reg + 2'h1;
    end
  end
  // Expected stored values, loaded on capture-clock rises
  always_ff @(posedge clk) begin
    aPrev_reg <= aSideCaptureClock;
    bPrev_reg <= bSideCaptureClock;
    if (aSideCaptureClock && !aPrev_reg) begin
      aSt_reg <= aIn;
    end
    if (bSideCaptureClock && !bPrev_reg) begin
      bSt_reg <= bIn;
    end
  end
  a_live_to_a: assert property (up && $past(toA) && !$past(bToASourceSelect) |->
    aOut == ($past(bIn) ^ mask)) else $error("live B to A wrong");
  a_stored_to_a: assert property (up && $past(stA) && !$past(bSideCaptureClock)
    && !$past(bSideCaptureClock, 2) |-> aOut == (bSt_reg ^ mask)) else $error("stored B to A wrong");
  a_live_to_b: assert property (up && $past(toB) && !$past(aToBSourceSelect) |->
    bOut == ($past(aIn) ^ mask)) else $error("live A to B wrong");
  a_stored_to_b: assert property (up && $past(stB) && !$past(aSideCaptureClock)
    && !$past(aSideCaptureClock, 2) |-> bOut == (aSt_reg ^ mask)) else $error("stored A to B wrong");
  a_a_drive: assert property (up |-> aOeN == !$past(toA)) else $error("A drive wrong");
  a_b_drive: assert property (up |-> bOeN == !$past(toB)) else $error("B drive wrong");
  a_isolate_both: assert property (up && $past(outputEnableN) |-> aOeN && bOeN)
    else $error("port driven while disabled");
  a_stored_hold: assert property (up && $past(stB) && $past(stB, 2) && !$past(aSideCaptureClock)
    && !$past(aSideCaptureClock, 2) && !$past(aSideCaptureClock, 3) |-> $stable(bOut)) else $error("store moved");
  c_stored_a: cover property (up && $past(stA));
  c_stored_b: cover property (up && $past(stB));
  c_isolated_capture: cover property (outputEnableN && $rose(aSideCaptureClock));
endmodule : obtr_properties

bind obtr_transceiver obtr_properties #(.INVERT_DATA(INVERT_DATA)) u_obtr_properties (.clk, .reset,
  .outputEnableN, .dirSelect, .aToBSourceSelect, .bToASourceSelect, .aSideCaptureClock, .bSideCaptureClock,
  .aIn, .bIn, .aOut, .bOut, .aOeN, .bOeN);

// >>> obtr_bus_agent.sv
/*
  Far-side bus agents; each drives its bus while the block releases it.
  Assumes enables are low while the block drives a port.
*/
`timescale 1ns/100ps
module obtr_bus_agent
  import obtr_pkg::*;
(
  // Block side
  input wire logic [DATA_W-1:0] aOut,
  input wire logic [DATA_W-1:0] bOut,
  input wire logic aOeN,
  input wire logic bOeN,
  // Agent values and wire levels
  input wire logic [DATA_W-1:0] aDrv,
  input wire logic [DATA_W-1:0] bDrv,
  output logic [DATA_W-1:0] aIn,
  output logic [DATA_W-1:0] bIn
);
  // Agent steps off a bus the block drives, so no contention
  assign aIn = aOeN ? aDrv : aOut;
  assign bIn = bOeN ? bDrv : bOut;
endmodule : obtr_bus_agent

// >>> obtr_transceiver_bench.sv
/*
  Bench for obtr_transceiver: data paths, capture, APB window.
  Assumes the bus agent model and the bound checker.
*/
`timescale 1ns/100ps
module obtr_transceiver_bench;
  import obtr_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, aOeN, bOeN;
  logic outputEnableN, dirSelect, aToBSourceSelect, bToASourceSelect, aSideCaptureClock, bSideCaptureClock;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata;
  logic [DATA_W-1:0] aIn, bIn, aOut, bOut, aDrv, bDrv;
  logic [DATA_W-1:0] aOutInv, bOutInv;
  int errorCnt = 0;
  int checks = 0;
  obtr_transceiver #(.INVERT_DATA(1'b0)) u_obtr_transceiver (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .outputEnableN, .dirSelect, .aToBSourceSelect,
    .bToASourceSelect, .aSideCaptureClock, .bSideCaptureClock, .aIn, .aOut, .aOeN, .bIn, .bOut, .bOeN);
  obtr_bus_agent u_obtr_bus_agent (.aOut, .bOut, .aOeN, .bOeN, .aDrv, .bDrv, .aIn, .bIn);
  // Inverting variant watching the same bus levels
  obtr_transceiver #(.INVERT_DATA(1'b1)) u_obtr_transceiver_inv (.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .outputEnableN, .dirSelect, .aToBSourceSelect,
    .bToASourceSelect, .aSideCaptureClock, .bSideCaptureClock, .aIn, .aOut(aOutInv), .aOeN(), .bIn,
    .bOut(bOutInv), .bOeN());
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    errorCnt++;
    results();
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // One APB transfer; d is write data or expected read data
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    tk(1);
    penable <= 1'b1;
    do begin
      tk(1);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 1'b1, pready);
    chk("pslverr", err, pslverr);
    if (!w) chk("prdata", d, prdata);
    {psel, penable} <= 2'h0;
    tk(1);
  endtask : apb
  task automatic results();
    $display("counts: %0d checks, %0d mismatches", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // Main sequence
  initial begin
    {psel, penable, pwrite, dirSelect, aToBSourceSelect, bToASourceSelect} = 6'h00;
    {aSideCaptureClock, bSideCaptureClock, paddr, pwdata, aDrv, bDrv} = 58'h0;
    outputEnableN = 1'b1;
    reset = 1'b1;
    tk(2);
    reset <= 1'b0;
    outputEnableN <= 1'b0;
    bDrv <= 8'hA5;
    tk(3);
    chk("aOut live", 8'hA5, aOut);
    chk("aOut live inverted", 8'h5A, aOutInv);
    chk("drive enables", 2'h1, {aOeN, bOeN});
    bSideCaptureClock <= 1'b1;
    tk(1);
    {bSideCaptureClock, bToASourceSelect, bDrv} <= {2'h1, 8'h3C};
    tk(4);
    chk("aOut stored", 8'hA5, aOut);
    chk("aOut stored inverted", 8'h5A, aOutInv);
    $display("done: B to A paths");
    {outputEnableN, dirSelect, aDrv} <= {2'h3, 8'h96};
    tk(2);
    chk("both released", 2'h3, {aOeN, bOeN});
    aSideCaptureClock <= 1'b1;
    tk(1);
    {aSideCaptureClock, aToBSourceSelect, outputEnableN, aDrv} <= {3'h2, 8'h69};
    tk(4);
    chk("bOut stored", 8'h96, bOut);
    chk("bOut stored inverted", 8'h69, bOutInv);
    aToBSourceSelect <= 1'b0;
    tk(2);
    chk("bOut live", 8'h69, bOut);
    chk("bOut live inverted", 8'h96, bOutInv);
    $display("done: A to B paths");
    apb(1'b0, STATUS_OFS, 32'h000AA596, 1'b0);
    apb(1'b0, CAPCNT_OFS, 32'h00010001, 1'b0);
    apb(1'b1, CTRL_OFS, 32'h00000001, 1'b0);
    apb(1'b0, CAPCNT_OFS, 32'h00000000, 1'b0);
    apb(1'b0, 8'h0C, 32'h00000000, 1'b1);
    $display("done: register window");
    results();
  end
endmodule : obtr_transceiver_bench
